// ==== rtl/code_b_decoder.sv ====
`timescale 1ns/1ps
module code_b_decoder
(
	input wire logic [7:0] raw, // Stored digit byte
	input wire logic decode_en, // Use code-B table
	output logic [7:0] segments // dp,a,b,c,d,e,f,g
);
	logic [6:0] glyph;

	always_comb
	begin
		unique case (raw[3:0])
			4'h0: glyph = 7'h7e;
			4'h1: glyph = 7'h30;
			4'h2: glyph = 7'h6d;
			4'h3: glyph = 7'h79;
			4'h4: glyph = 7'h33;
			4'h5: glyph = 7'h5b;
			4'h6: glyph = 7'h5f;
			4'h7: glyph = 7'h70;
			4'h8: glyph = 7'h7f;
			4'h9: glyph = 7'h7b;
			4'ha: glyph = 7'h01;
			4'hb: glyph = 7'h4f;
			4'hc: glyph = 7'h37;
			4'hd: glyph = 7'h0e;
			4'he: glyph = 7'h67;
			4'hf: glyph = 7'h00;
		endcase
	end

	// Decimal point stays under direct control in both modes
	assign segments = decode_en ? {raw[7], glyph} : raw;
endmodule : code_b_decoder

// ==== rtl/led_digit_driver.sv ====
`timescale 1ns/1ps
module led_digit_driver
	import led_driver_pkg::*;
#(
	parameter int SCAN_DIV = SCAN_SLOT_CYC
)
(
	input wire logic pclk, // Clock, 250 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic [11:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic serial_clk, // Serial clock pin
	input wire logic serial_din, // Serial data pin
	input wire logic load_strobe, // Word latch strobe pin
	input wire logic ext_scan_clk, // External scan clock pin
	output logic serial_dout, // Cascade data out
	output logic [7:0] digit_drive_lines, // Digit sinks, low selects
	output logic [7:0] segment_drive_lines // dp,a..g, high lights
);
	localparam int PIN_N = 4;
	localparam int DIV_W = $clog2(SCAN_DIV + 1);

	logic [PIN_N-1:0] pin_vec;
	logic [PIN_N-1:0] sync1_q, sync2_q, sync3_q;
	logic clk_rise, clk_fall, load_rise, ext_rise, din_s;
	logic [WORD_W-1:0] sr_q, last_word_q;
	logic out_bit_q, dout_q;
	logic [7:0] digit_mem_q [DIGITS];
	logic [7:0] decode_q;
	logic [3:0] intensity_q;
	logic [2:0] limit_q;
	logic shutdown_q, test_q, clksel_q, link_en_q;
	logic [SEL_W-1:0] sel;
	logic [7:0] val;
	logic [DIV_W-1:0] div_q;
	logic int_tick, scan_tick;
	logic [SUB_W-1:0] sub_q;
	logic [2:0] idx_q;
	logic [7:0] pattern, digit_q, seg_q;
	logic apb_hit;
	logic [31:0] rd_data, prdata_q;
	logic pready_q, pslverr_q;

	// Pins come from outside the pclk domain; only stages two and three feed logic
	assign pin_vec = {ext_scan_clk, load_strobe, serial_din, serial_clk};
	generate
		for (genvar i = 0; i < PIN_N; i++)
		begin : g_sync
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					{sync3_q[i], sync2_q[i], sync1_q[i]} <= 3'h0;
				else
					{sync3_q[i], sync2_q[i], sync1_q[i]} <= {sync2_q[i], sync1_q[i], pin_vec[i]};
			end
		end
	endgenerate

	assign clk_rise = sync2_q[0] & ~sync3_q[0];
	assign clk_fall = ~sync2_q[0] & sync3_q[0];
	assign din_s = sync2_q[1];
	assign load_rise = sync2_q[2] & ~sync3_q[2];
	assign ext_rise = sync2_q[3] & ~sync3_q[3];

	// Shift path; the extra stage gives the half clock beyond sixteen
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sr_q <= '0;
			out_bit_q <= 1'b0;
		end
		else if (clk_rise)
		begin
			sr_q <= {sr_q[WORD_W-2:0], din_s};
			out_bit_q <= sr_q[WORD_W-1];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dout_q <= 1'b0;
		else if (clk_fall)
			dout_q <= out_bit_q;
	end

	assign serial_dout = dout_q;

	// Word decode, first bit shifted is the MSB
	assign sel = sr_q[SEL_LSB +: SEL_W];
	assign val = sr_q[7:0];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			last_word_q <= '0;
		else if (load_rise)
			last_word_q <= sr_q;
	end

	// Settings storage; a serial reset restores power-up values
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int d = 0; d < DIGITS; d++)
				digit_mem_q[d] <= RST_DIGIT;
			decode_q <= RST_DECODE;
			intensity_q <= RST_INTENSITY;
			limit_q <= RST_LIMIT;
			shutdown_q <= RST_SHUTDOWN;
			test_q <= 1'b0;
			clksel_q <= 1'b0;
		end
		else if (load_rise && link_en_q)
		begin
			if (sel >= SEL_DIGIT0 && sel <= SEL_DIGIT7)
				digit_mem_q[3'(sel - SEL_DIGIT0)] <= val;
			else if (sel == SEL_DECODE)
				decode_q <= val;
			else if (sel == SEL_INTENSITY)
				intensity_q <= val[3:0];
			else if (sel == SEL_LIMIT)
				limit_q <= val[2:0];
			else if (sel == SEL_SHUTDOWN)
				shutdown_q <= ~val[0];
			else if (sel == SEL_CLKSEL)
				clksel_q <= val[0];
			else if (sel == SEL_TEST)
				test_q <= val[0];
			else if (sel == SEL_SWRESET)
			begin
				for (int d = 0; d < DIGITS; d++)
					digit_mem_q[d] <= RST_DIGIT;
				decode_q <= RST_DECODE;
				intensity_q <= RST_INTENSITY;
				limit_q <= RST_LIMIT;
				shutdown_q <= RST_SHUTDOWN;
				test_q <= 1'b0;
				clksel_q <= 1'b0;
			end
		end
	end

	// Scan timing: internal divider or external clock edges
	assign int_tick = (div_q == DIV_W'(SCAN_DIV - 1));
	assign scan_tick = clksel_q ? ext_rise : int_tick;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_q <= '0;
		else if (int_tick)
			div_q <= '0;
		else
			div_q <= div_q + 1'b1;
	end

	// Each digit slot is split into 16 sub-slots for duty-cycle dimming
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sub_q <= '0;
			idx_q <= '0;
		end
		else if (idx_q > limit_q)
		begin
			sub_q <= '0;
			idx_q <= '0;
		end
		else if (scan_tick)
		begin
			sub_q <= sub_q + 1'b1;
			if (sub_q == {SUB_W{1'b1}})
				idx_q <= (idx_q == limit_q) ? 3'h0 : idx_q + 3'h1;
		end
	end

	code_b_decoder u_dec
	(
		.raw(digit_mem_q[idx_q]),
		.decode_en(decode_q[idx_q]),
		.segments(pattern)
	);

	// Test mode wins over shutdown so wiring can be checked while blanked
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			digit_q <= 8'hff;
			seg_q <= 8'h00;
		end
		else if (shutdown_q && !test_q)
		begin
			digit_q <= 8'hff;
			seg_q <= 8'h00;
		end
		else
		begin
			digit_q <= ~(8'h01 << idx_q);
			if (test_q)
				seg_q <= 8'hff;
			else if (sub_q <= intensity_q)
				seg_q <= pattern;
			else
				seg_q <= 8'h00;
		end
	end

	assign digit_drive_lines = digit_q;
	assign segment_drive_lines = seg_q;

	// APB slave: one wait state, write lands at the edge that sees pready
	assign apb_hit = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_WORD);

	always_comb
	begin
		rd_data = 32'h0;
		if (paddr == OFS_CTRL)
			rd_data = {31'h0, link_en_q};
		else if (paddr == OFS_STATUS)
			rd_data = {16'h0, 1'b0, idx_q, 1'b0, limit_q, intensity_q, 1'b0, clksel_q, test_q, shutdown_q};
		else if (paddr == OFS_WORD)
			rd_data = {16'h0, last_word_q};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end
		else if (psel && penable && !pready_q)
		begin
			pready_q <= 1'b1;
			pslverr_q <= ~apb_hit;
			prdata_q <= pwrite ? 32'h0 : rd_data;
		end
		else
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			link_en_q <= RST_LINK_EN;
		else if (psel && penable && pready_q && pwrite && paddr == OFS_CTRL)
			link_en_q <= pwdata[0];
	end

	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_shift;
		clk_rise |=> sr_q == {$past(sr_q[WORD_W-2:0]), $past(din_s)};
	endproperty
	a_shift: assert property (p_shift) else $error("shift register did not take input bit");
	property p_latch;
		load_rise |=> last_word_q == $past(sr_q);
	endproperty
	a_latch: assert property (p_latch) else $error("strobe did not latch word");
	property p_dout_fall;
		clk_fall |=> serial_dout == $past(out_bit_q);
	endproperty
	a_dout_fall: assert property (p_dout_fall) else $error("serial out missed falling edge");
	property p_dout_hold;
		!clk_fall |=> $stable(serial_dout);
	endproperty
	a_dout_hold: assert property (p_dout_hold) else $error("serial out changed off falling edge");
	property p_shutdown;
		shutdown_q && !test_q |=> digit_drive_lines == 8'hff && segment_drive_lines == 8'h00;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("display not blank in shutdown");
	property p_one_digit;
		!shutdown_q ##1 !$past(shutdown_q) |-> $countones(~digit_drive_lines) == 1;
	endproperty
	a_one_digit: assert property (p_one_digit) else $error("not exactly one digit selected");
	property p_limit;
		idx_q > limit_q |=> idx_q == 3'h0;
	endproperty
	a_limit: assert property (p_limit) else $error("scan index beyond digit count");
	property p_dim;
		!shutdown_q && !test_q && sub_q > intensity_q |=> segment_drive_lines == 8'h00;
	endproperty
	a_dim: assert property (p_dim) else $error("segments lit outside brightness window");
	property p_swreset;
		load_rise && link_en_q && sel == SEL_SWRESET |=> shutdown_q ##1 digit_drive_lines == 8'hff;
	endproperty
	a_swreset: assert property (p_swreset) else $error("serial reset did not blank display");
	property p_test;
		test_q |=> segment_drive_lines == 8'hff;
	endproperty
	a_test: assert property (p_test) else $error("test mode did not light all segments");

	c_digit_write: cover property (load_rise && link_en_q && sel == SEL_DIGIT0);
	c_wake: cover property (shutdown_q ##1 !shutdown_q);
	c_ext_scan: cover property (clksel_q && ext_rise);
	c_apb_read: cover property (pready && !pslverr && !pwrite);
endmodule : led_digit_driver

// ==== rtl/led_driver_pkg.sv ====
package led_driver_pkg;
	// Serial word layout: selector in the upper byte, value in the lower byte, MSB first
	localparam int WORD_W = 16;
	localparam int SEL_LSB = 8;
	localparam int SEL_W = 4;
	localparam int DIGITS = 8;
	localparam int SUB_W = 4;

	localparam logic [3:0] SEL_NOOP = 4'h0;
	localparam logic [3:0] SEL_DIGIT0 = 4'h1;
	localparam logic [3:0] SEL_DIGIT7 = 4'h8;
	localparam logic [3:0] SEL_DECODE = 4'h9;
	localparam logic [3:0] SEL_INTENSITY = 4'ha;
	localparam logic [3:0] SEL_LIMIT = 4'hb;
	localparam logic [3:0] SEL_SHUTDOWN = 4'hc;
	localparam logic [3:0] SEL_SWRESET = 4'hd;
	localparam logic [3:0] SEL_CLKSEL = 4'he;
	localparam logic [3:0] SEL_TEST = 4'hf;

	localparam logic [7:0] RST_DIGIT = 8'h00;
	localparam logic [7:0] RST_DECODE = 8'h00;
	localparam logic [3:0] RST_INTENSITY = 4'h0;
	localparam logic [2:0] RST_LIMIT = 3'h7;
	localparam logic RST_SHUTDOWN = 1'b1;

	// APB register map
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_WORD = 12'h008;
	localparam logic RST_LINK_EN = 1'b1;

	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int LINK_MAX_KHZ = 10000;
	localparam int SCAN_SLOT_NS = 1000;
	localparam int SCAN_SLOT_CYC = (SCAN_SLOT_NS / CLK_PERIOD_NS < 1) ? 1 : SCAN_SLOT_NS / CLK_PERIOD_NS;
endpackage : led_driver_pkg

// ==== testbench/serial_host_model.sv ====
`timescale 1ns/1ps
module serial_host_model
(
	input wire logic pclk, // Bench clock
	input wire logic serial_dout, // Cascade data from the driver
	output logic serial_clk, // Link clock
	output logic serial_din, // Link data
	output logic load_strobe, // Word latch
	output logic [15:0] cap // Cascade bits seen before each rise
);
	initial
	begin
		serial_clk = 1'b0;
		serial_din = 1'b0;
		load_strobe = 1'b0;
		cap = 16'h0;
	end
	// Six pclk a level gives 48 ns a period
	task automatic half();
		repeat (6) @(posedge pclk);
	endtask : half
	task automatic send(input logic [15:0] w);
		for (int i = 15; i >= 0; i--)
		begin
			serial_clk <= 1'b0;
			serial_din <= w[i];
			half();
			cap <= {cap[14:0], serial_dout};
			serial_clk <= 1'b1;
			half();
		end
		// Clock parks low; data flips so a stale bit cannot pass for a driven one
		serial_clk <= 1'b0;
		serial_din <= ~w[0];
		half();
		load_strobe <= 1'b1;
		half();
		load_strobe <= 1'b0;
		half();
	endtask : send
endmodule : serial_host_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
	import led_driver_pkg::*;
	localparam logic [7:0] CB[16] = '{8'h7e, 8'h30, 8'h6d, 8'h79, 8'h33, 8'h5b, 8'h5f, 8'h70,
		8'h7f, 8'h7b, 8'h01, 8'h4f, 8'h37, 8'h0e, 8'h67, 8'h00};
	localparam logic [31:0] SM = 32'hffff8fff;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_scan_clk, errv, ext_run;
	logic sclk, sdin, sload, sdout;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [7:0] dig, seg, seg0, seen;
	logic [15:0] cap;
	int n_errors, num_checks;
	led_digit_driver #(.SCAN_DIV(2)) u_led_digit_driver (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_clk(sclk), .serial_din(sdin), .load_strobe(sload),
		.ext_scan_clk(ext_scan_clk), .serial_dout(sdout), .digit_drive_lines(dig), .segment_drive_lines(seg));
	serial_host_model u_serial_host_model (.pclk(pclk), .serial_dout(sdout), .serial_clk(sclk),
		.serial_din(sdin), .load_strobe(sload), .cap(cap));
	function automatic logic [7:0] cb(input logic [7:0] v);
		return CB[v[3:0]] | {v[7], 7'h0};
	endfunction : cb
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			$display("MISMATCH %s exp %h got %h", nm, e, g);
			n_errors++;
		end
	endtask : chk
	task automatic wrap_up();
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
		begin
			n_errors++;
			wrap_up();
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rdv & m);
	endtask : rdc
	task automatic lw(input logic [3:0] s, input logic [7:0] v);
		u_serial_host_model.send({4'h0, s, v});
	endtask : lw
	// Scan slots are short, so a few hundred cycles cover every selected digit
	task automatic observe(input int n);
		seen = 8'h0;
		seg0 = 8'hxx;
		repeat (n)
		begin
			@(posedge pclk);
			if (dig !== 8'hff)
				seen = seen | ~dig;
			if (dig === 8'hfe)
				seg0 = seg;
		end
	endtask : observe
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial
	begin
		ext_scan_clk = 1'b0;
		forever
		begin
			repeat (3) @(posedge pclk);
			if (ext_run)
				ext_scan_clk <= ~ext_scan_clk;
		end
	end
	initial
	begin
		logic [7:0] v;
		logic [15:0] wa, wb;
		n_errors = 0;
		num_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		ext_run = 1'b1;
		void'($urandom(32'h2076));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		chk("digits", 32'hff, 32'(dig));
		chk("segs", 32'h0, 32'(seg));
		rdc(OFS_CTRL, 32'h1, 32'hffffffff, "ctrl");
		rdc(OFS_STATUS, 32'h0701, SM, "status");
		apb(1'b0, 12'h00c, 32'h0);
		chk("slverr", 32'h1, 32'(errv));
		chk("unmapped", 32'h0, rdv);
		observe(200);
		chk("blank", 32'h0, 32'(seen));
		wa = {4'h0, SEL_DIGIT0, 8'($urandom)};
		wb = {4'h0, SEL_NOOP, 8'($urandom)};
		lw(wa[11:8], wa[7:0]);
		lw(wb[11:8], wb[7:0]);
		chk("cascade", 32'(wa[15:1]), 32'(cap[14:0]));
		rdc(OFS_WORD, 32'(wb), 32'hffffffff, "word");
		lw(SEL_LIMIT, 8'h0);
		lw(SEL_INTENSITY, 8'h0f);
		lw(SEL_SHUTDOWN, 8'h01);
		rdc(OFS_STATUS, 32'h00f0, SM, "status");
		observe(300);
		chk("scan", 32'h1, 32'(seen));
		chk("direct", 32'(wa[7:0]), 32'(seg0));
		lw(SEL_LIMIT, 8'h1);
		lw(4'(SEL_DIGIT0 + 1), 8'($urandom));
		observe(300);
		chk("scan2", 32'h3, 32'(seen));
		chk("keep", 32'(wa[7:0]), 32'(seg0));
		lw(SEL_LIMIT, 8'h0);
		lw(SEL_DECODE, 8'h01);
		repeat (4)
		begin
			v = 8'($urandom);
			lw(SEL_DIGIT0, v);
			observe(150);
			chk("decode", 32'(cb(v)), 32'(seg0));
		end
		lw(SEL_SHUTDOWN, 8'h00);
		observe(200);
		chk("shutdown", 32'h0, 32'(seen));
		lw(SEL_SHUTDOWN, 8'h01);
		observe(200);
		chk("resume", 32'(cb(v)), 32'(seg0));
		lw(SEL_TEST, 8'h01);
		observe(150);
		chk("test", 32'hff, 32'(seg0));
		lw(SEL_TEST, 8'h00);
		lw(SEL_CLKSEL, 8'h01);
		rdc(OFS_STATUS, 32'h4, 32'h4, "extsel");
		observe(400);
		chk("extscan", 32'(cb(v)), 32'(seg0));
		// Stopping the external clock must freeze the scan on one digit
		lw(SEL_LIMIT, 8'h1);
		ext_run <= 1'b0;
		repeat (10) @(posedge pclk);
		observe(300);
		chk("extstop", 32'h1, 32'($countones(seen)));
		ext_run <= 1'b1;
		observe(400);
		chk("extrun", 32'h3, 32'(seen));
		lw(SEL_LIMIT, 8'h0);
		lw(SEL_CLKSEL, 8'h00);
		// Link disabled: word still captured, settings untouched
		apb(1'b1, OFS_CTRL, 32'h0);
		lw(SEL_INTENSITY, 8'h03);
		rdc(OFS_STATUS, 32'h00f0, 32'h00f0, "gated");
		rdc(OFS_WORD, 32'h0a03, 32'hffffffff, "word2");
		apb(1'b1, OFS_CTRL, 32'h1);
		lw(SEL_SWRESET, 8'h00);
		rdc(OFS_STATUS, 32'h0701, SM, "swreset");
		observe(200);
		chk("blank2", 32'h0, 32'(seen));
		// Mid-run reset with the display lit and the link disabled
		lw(SEL_SHUTDOWN, 8'h01);
		apb(1'b1, OFS_CTRL, 32'h0);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc(OFS_CTRL, 32'h1, 32'hffffffff, "ctrl2");
		observe(100);
		chk("blank3", 32'h0, 32'(seen));
		wrap_up();
	end
endmodule : tb
